// [inc/pwrseq_defs.svh]
`ifndef PWRSEQ_DEFS_SVH
`define PWRSEQ_DEFS_SVH
`default_nettype none

// adapter clock rate in hertz (250 MHz)
`define CLK_FREQ_HZ 32'h0EE6B280
// power-up watchdog time in seconds (35 s)
`define POWERUP_TIME_S 8'h23
// width of the watchdog counter
`define TIMER_W 34

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ATTN 8'h08
`define REG_MAINT2 8'h0C
`define REG_ECC 8'h10
`define REG_ERR1 8'h14
`define REG_ERR2 8'h18
`define REG_TIMER 8'h1C

// field positions
`define CTRL_SEARCH_BIT 0
`define CTRL_ON_BIT 1
`define CTRL_DCLR_BIT 2
`define ATTN_FLAG_BIT 0
`define MAINT2_CLR_BIT 0
`define ERR1_TMO_BIT 0

// reset values
`define RST_ON_LATCH 1'b1
`define RST_REG16 16'h0000

`default_nettype wire
`endif

// [inc/pwrseq_pkg.sv]
`default_nettype none
package pwrseq_pkg;

   // power-up sequence states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARM,
      ST_RUN,
      ST_UP,
      ST_FAILED
   } seq_state_t;

   // whole state of the sequencer top
   typedef struct packed {
      seq_state_t state;
      logic grant_out;
      logic busy_oe_n;
      logic busy_drv;
      logic pick;
      logic hold;
      logic grant_relay;
      logic start_relay;
      logic fault;
      logic attention;
      logic enable_search;
      logic on_latch;
      logic dc_ok_prev;
      logic [15:0] maint2;
      logic [15:0] ecc_pattern;
      logic [15:0] err1;
      logic [15:0] err2;
      logic ack;
      logic err;
      logic [31:0] rdata;
   } seq_regs_t;

endpackage
`default_nettype wire

// [logic/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_regs_t;

   sync_regs_t r_q;
   sync_regs_t r_d;

   if (W < 1) begin : g_bad_w
      $error("pin_sync needs at least one bit");
   end

   // three stages; output follows once stages two and three agree
   always_comb begin
      r_d = r_q;
      r_d.s1 = d_i;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      r_d.q = (r_q.s2 & r_q.s3) | (r_q.q & (r_q.s2 | r_q.s3));
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
      end else begin
         r_q <= r_d;
      end
   end

   assign q_o = r_q.q;
endmodule
`default_nettype wire

// [logic/power_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module power_timer #(
   parameter int W = 34,
   parameter logic [63:0] LIMIT = 64'h0000_0002_098A_6780
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic run_i,
   output logic expired_o,
   output logic [W-1:0] count_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic expired;
   } tmr_regs_t;

   localparam logic [W-1:0] LAST = W'(LIMIT - 64'h1);

   tmr_regs_t r_q;
   tmr_regs_t r_d;

   if (W < 1 || W > 63 || LIMIT == 64'h0 || LIMIT > (64'h1 << W)) begin : g_bad_limit
      $error("power_timer limit does not fit its counter");
   end

   // restart on start, count while running, latch expiry
   always_comb begin
      r_d = r_q;
      if (start_i) begin
         r_d.cnt = '0;
         r_d.expired = 1'b0;
      end else if (run_i && !r_q.expired) begin
         if (r_q.cnt == LAST) begin
            r_d.expired = 1'b1;
         end else begin
            r_d.cnt = r_q.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_q <= '{cnt: '0, expired: 1'b0};
      end else begin
         r_q <= r_d;
      end
   end

   assign expired_o = r_q.expired;
   assign count_o = r_q.cnt;
endmodule
`default_nettype wire

// [logic/drive_power_up_chain_and_init.sv]
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "pwrseq_defs.svh"
`default_nettype none
module drive_power_up_chain_and_init #(
   parameter logic [63:0] POWERUP_CYCLES = 64'(`POWERUP_TIME_S) * 64'(`CLK_FREQ_HZ),
   parameter int TIMER_W = `TIMER_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // power sequence cable
   input wire logic grant_in_n_i,
   output logic grant_out_n_o,
   input wire logic seq_busy_n_i,
   output logic seq_busy_n_o,
   output logic seq_busy_oe_n_o,
   // drive side
   input wire logic start_enable_i,
   input wire logic dc_power_ok_i,
   input wire logic unit_ready_i,
   output logic pick_o,
   output logic hold_o,
   output logic start_relay_o,
   output logic grant_relay_o,
   // bus initialize from the two host ports
   input wire logic bus_init_a_i,
   input wire logic bus_init_b_i
);
   localparam pwrseq_pkg::seq_regs_t RESET_STATE = '{
      state: pwrseq_pkg::ST_IDLE,
      grant_out: 1'b1,
      busy_oe_n: 1'b1,
      busy_drv: 1'b0,
      pick: 1'b1,
      hold: 1'b1,
      grant_relay: 1'b0,
      start_relay: 1'b0,
      fault: 1'b0,
      attention: 1'b0,
      enable_search: 1'b0,
      on_latch: `RST_ON_LATCH,
      dc_ok_prev: 1'b0,
      maint2: `RST_REG16,
      ecc_pattern: `RST_REG16,
      err1: `RST_REG16,
      err2: `RST_REG16,
      ack: 1'b0,
      err: 1'b0,
      rdata: 32'h0000_0000
   };
   // merge the two low byte lanes of a write into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0] sel);
      logic [15:0] res;
      res = old;
      if (sel[0]) begin
         res[7:0] = wdat[7:0];
      end
      if (sel[1]) begin
         res[15:8] = wdat[15:8];
      end
      return res;
   endfunction
   // true for every mapped register offset
   function automatic logic reg_hit(input logic [7:0] adr);
      logic hit;
      hit = 1'b0;
      case (adr)
         `REG_CTRL, `REG_STATUS, `REG_ATTN, `REG_MAINT2,
         `REG_ECC, `REG_ERR1, `REG_ERR2, `REG_TIMER: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction
   pwrseq_pkg::seq_regs_t r_q;
   pwrseq_pkg::seq_regs_t r_d;
   logic grant_in_n_s;
   logic seq_busy_n_s;
   logic unit_ready_s;
   logic start_en_s;
   logic dc_ok_s;
   logic init_a_s;
   logic init_b_s;
   logic tmr_expired;
   logic [TIMER_W-1:0] tmr_count;
   logic tmr_start;
   logic tmr_run;
   logic bus_req;
   logic wr;
   logic drive_clear;
   logic adapter_clear;
   logic start_ok;
   logic ev_ready;
   logic ev_timeout;
   // all cable and drive pins come from outside the clock domain
   pin_sync #(
      .W(7),
      .RST_VAL(7'h03)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({bus_init_b_i, bus_init_a_i, dc_power_ok_i, start_enable_i,
            unit_ready_i, seq_busy_n_i, grant_in_n_i}),
      .q_o({init_b_s, init_a_s, dc_ok_s, start_en_s,
            unit_ready_s, seq_busy_n_s, grant_in_n_s})
   );
   power_timer #(
      .W(TIMER_W),
      .LIMIT(POWERUP_CYCLES)
   ) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(tmr_start),
      .run_i(tmr_run),
      .expired_o(tmr_expired),
      .count_o(tmr_count)
   );
   // next-state logic for bus, clear sequence and power-up sequencer
   always_comb begin
      r_d = r_q;
      r_d.ack = 1'b0;
      r_d.err = 1'b0;
      r_d.busy_drv = 1'b0;
      r_d.dc_ok_prev = dc_ok_s;
      bus_req = wb_cyc_i && wb_stb_i && !r_q.ack && !r_q.err;
      wr = bus_req && wb_we_i && reg_hit(wb_adr_i);
      drive_clear = wr && wb_adr_i == `REG_CTRL && wb_sel_i[0] && wb_dat_i[`CTRL_DCLR_BIT];
      // bus initialize from either port, power good edge and drive clear
      adapter_clear = init_a_s || init_b_s || (dc_ok_s && !r_q.dc_ok_prev) || drive_clear;
      start_ok = start_en_s && dc_ok_s && !grant_in_n_s && !r_q.fault;
      ev_ready = r_q.state == pwrseq_pkg::ST_RUN && unit_ready_s;
      ev_timeout = r_q.state == pwrseq_pkg::ST_RUN && tmr_expired && !unit_ready_s;
      tmr_start = 1'b0;
      tmr_run = r_q.state == pwrseq_pkg::ST_RUN && !unit_ready_s;
      // single-cycle answer, error for unmapped offsets
      if (bus_req) begin
         r_d.ack = reg_hit(wb_adr_i);
         r_d.err = !reg_hit(wb_adr_i);
         r_d.rdata = 32'h0000_0000;
         case (wb_adr_i)
            `REG_CTRL: begin
               r_d.rdata[`CTRL_SEARCH_BIT] = r_q.enable_search;
               r_d.rdata[`CTRL_ON_BIT] = r_q.on_latch;
            end
            `REG_STATUS: begin
               r_d.rdata[9:0] = {dc_ok_s, start_en_s, unit_ready_s, !grant_in_n_s,
                                 !seq_busy_n_s, r_q.start_relay, r_q.grant_relay,
                                 r_q.fault, r_q.state == pwrseq_pkg::ST_RUN,
                                 r_q.state == pwrseq_pkg::ST_UP};
            end
            `REG_ATTN: begin
               r_d.rdata[`ATTN_FLAG_BIT] = r_q.attention;
            end
            `REG_MAINT2: begin
               r_d.rdata[15:0] = r_q.maint2;
            end
            `REG_ECC: begin
               r_d.rdata[15:0] = r_q.ecc_pattern;
            end
            `REG_ERR1: begin
               r_d.rdata[15:0] = r_q.err1;
            end
            `REG_ERR2: begin
               r_d.rdata[15:0] = r_q.err2;
            end
            `REG_TIMER: begin
               r_d.rdata = 32'(tmr_count); // count bits above 31 are cut off
            end
            default: begin
               r_d.rdata = 32'h0000_0000;
            end
         endcase
      end
      // software writes
      if (wr) begin
         case (wb_adr_i)
            `REG_CTRL: begin
               if (wb_sel_i[0]) begin
                  r_d.enable_search = wb_dat_i[`CTRL_SEARCH_BIT];
                  r_d.on_latch = wb_dat_i[`CTRL_ON_BIT];
               end
            end
            `REG_ATTN: begin
               if (wb_sel_i[0] && wb_dat_i[`ATTN_FLAG_BIT]) begin
                  r_d.attention = 1'b0;
               end
            end
            `REG_MAINT2: begin
               r_d.maint2 = merge16(r_q.maint2, wb_dat_i, wb_sel_i);
            end
            `REG_ECC: begin
               r_d.ecc_pattern = merge16(r_q.ecc_pattern, wb_dat_i, wb_sel_i);
            end
            `REG_ERR1: begin
               r_d.err1 = r_q.err1 & ~merge16(16'h0000, wb_dat_i, wb_sel_i); // write one to clear
            end
            `REG_ERR2: begin
               r_d.err2 = merge16(r_q.err2, wb_dat_i, wb_sel_i);
            end
            default: begin
               r_d.err2 = r_d.err2;
            end
         endcase
      end

      // adapter clear actions
      if (adapter_clear) begin
         r_d.attention = 1'b0;
         // search, on latch, maint bit, ecc, both error registers; fault only with start enable off or unit ready
         r_d.enable_search = 1'b0;
         r_d.on_latch = 1'b1;
         r_d.maint2[`MAINT2_CLR_BIT] = 1'b0;
         r_d.ecc_pattern = 16'h0000;
         r_d.err1 = 16'h0000;
         r_d.err2 = 16'h0000;
         if (!start_en_s || unit_ready_s) begin
            r_d.fault = 1'b0;
         end
      end

      // power-up sequencer; hardware events land after clears
      case (r_q.state)
         pwrseq_pkg::ST_IDLE: begin
            r_d.grant_out = grant_in_n_s;
            r_d.grant_relay = 1'b0;
            if (start_ok) begin
               r_d.state = pwrseq_pkg::ST_ARM;
               r_d.grant_relay = 1'b1;
               r_d.grant_out = 1'b1;
            end
         end
         pwrseq_pkg::ST_ARM: begin
            if (!start_ok) begin
               r_d.state = pwrseq_pkg::ST_IDLE;
               r_d.grant_relay = 1'b0;
               r_d.grant_out = grant_in_n_s;
            end else if (seq_busy_n_s) begin
               r_d.state = pwrseq_pkg::ST_RUN;
               r_d.pick = 1'b0;
               r_d.hold = 1'b0;
               r_d.start_relay = 1'b1;
               tmr_start = 1'b1;
               r_d.busy_oe_n = 1'b0;
            end
         end
         pwrseq_pkg::ST_RUN: begin
            if (ev_ready || ev_timeout) begin
               r_d.grant_out = 1'b0;
               r_d.grant_relay = 1'b0;
               r_d.busy_oe_n = 1'b1;
               r_d.attention = 1'b1;
               r_d.state = ev_ready ? pwrseq_pkg::ST_UP : pwrseq_pkg::ST_FAILED;
               if (ev_timeout) begin
                  r_d.fault = 1'b1;
                  r_d.err1[`ERR1_TMO_BIT] = 1'b1;
                  r_d.pick = 1'b1;
                  r_d.hold = 1'b1;
                  r_d.start_relay = 1'b0;
               end
            end else if (!start_en_s) begin
               r_d.state = pwrseq_pkg::ST_IDLE;
               r_d.pick = 1'b1;
               r_d.hold = 1'b1;
               r_d.start_relay = 1'b0;
               r_d.busy_oe_n = 1'b1;
               r_d.grant_relay = 1'b0;
               r_d.grant_out = grant_in_n_s;
            end
         end
         pwrseq_pkg::ST_UP: begin
            r_d.grant_out = 1'b0;
            if (!start_en_s) begin
               r_d.state = pwrseq_pkg::ST_IDLE;
               r_d.pick = 1'b1;
               r_d.hold = 1'b1;
               r_d.start_relay = 1'b0;
               r_d.grant_out = grant_in_n_s;
            end
         end
         pwrseq_pkg::ST_FAILED: begin
            r_d.grant_out = 1'b0;
            if (!r_d.fault) begin
               r_d.state = pwrseq_pkg::ST_IDLE;
            end
         end
         default: begin
            r_d = RESET_STATE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_q <= RESET_STATE;
      end else begin
         r_q <= r_d;
      end
   end

   // every output straight from the state register
   assign wb_dat_o = r_q.rdata;
   assign wb_ack_o = r_q.ack;
   assign wb_err_o = r_q.err;
   assign grant_out_n_o = r_q.grant_out;
   assign seq_busy_n_o = r_q.busy_drv;
   assign seq_busy_oe_n_o = r_q.busy_oe_n;
   assign pick_o = r_q.pick;
   assign hold_o = r_q.hold;
   assign start_relay_o = r_q.start_relay;
   assign grant_relay_o = r_q.grant_relay;
endmodule
`default_nettype wire

// [tb/drive_power_up_chain_and_init_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module pwrseq_checker #(
   parameter logic [63:0] POWERUP_CYCLES = 64'h0000_0000_0000_00C8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic grant_in_n_i,
   input wire logic grant_out_n_o,
   input wire logic seq_busy_n_i,
   input wire logic seq_busy_oe_n_o,
   input wire logic start_enable_i,
   input wire logic dc_power_ok_i,
   input wire logic unit_ready_i,
   input wire logic pick_o,
   input wire logic hold_o,
   input wire logic start_relay_o,
   input wire logic grant_relay_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] low_cnt_q;
   // cycles the busy line has been pulled by this adapter
   always_ff @(posedge clk_i) begin
      if (rst_i || seq_busy_oe_n_o) begin
         low_cnt_q <= 32'h0;
      end else begin
         low_cnt_q <= low_cnt_q + 32'h1;
      end
   end
   relay_breaks_grant_a: assert property ($rose(grant_relay_o) |-> grant_out_n_o)
      else $error("grant passed on while relay energized");
   start_needs_all_a: assert property ($rose(grant_relay_o) |->
      $past(start_enable_i, 3) && $past(dc_power_ok_i, 3) && !$past(grant_in_n_i, 3))
      else $error("sequence started without its conditions");
   busy_free_first_a: assert property ($fell(seq_busy_oe_n_o) |-> $past(grant_relay_o) && $past(seq_busy_n_i, 3))
      else $error("busy line pulled while another adapter sequencing");
   run_outputs_a: assert property ($fell(seq_busy_oe_n_o) |-> !pick_o && !hold_o && start_relay_o)
      else $error("pick or hold not negated at run start");
   release_grants_a: assert property ($rose(seq_busy_oe_n_o) |-> !grant_out_n_o && !grant_relay_o)
      else $error("busy released without grant out");
   ready_ends_run_a: assert property (!seq_busy_oe_n_o && unit_ready_i |-> ##[1:6] seq_busy_oe_n_o)
      else $error("unit ready did not end the run");
   timer_bound_a: assert property (64'(low_cnt_q) <= POWERUP_CYCLES + 64'h2)
      else $error("run outlived the power-up timer");
   stop_drive_a: assert property (start_relay_o && seq_busy_oe_n_o && $fell(start_enable_i) |->
      ##[2:6] (pick_o && hold_o && !start_relay_o))
      else $error("stop did not assert pick and hold");
   pass_through_a: assert property (!start_enable_i && !grant_relay_o && !start_relay_o && $changed(grant_in_n_i) |->
      ##[3:6] (grant_out_n_o == grant_in_n_i))
      else $error("stopped adapter did not pass grant");
   wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
      else $error("bus request not answered next cycle");
   cover property ($fell(seq_busy_oe_n_o));
   cover property ($rose(seq_busy_oe_n_o) && pick_o);
   cover property (wb_err_o);
endmodule
bind drive_power_up_chain_and_init pwrseq_checker #(.POWERUP_CYCLES(POWERUP_CYCLES)) chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .grant_in_n_i(grant_in_n_i), .grant_out_n_o(grant_out_n_o),
   .seq_busy_n_i(seq_busy_n_i), .seq_busy_oe_n_o(seq_busy_oe_n_o), .start_enable_i(start_enable_i),
   .dc_power_ok_i(dc_power_ok_i), .unit_ready_i(unit_ready_i), .pick_o(pick_o), .hold_o(hold_o),
   .start_relay_o(start_relay_o), .grant_relay_o(grant_relay_o));
`default_nettype wire

// [tb/neighbour_adapter.sv]
`timescale 1ns/1ps
`default_nettype none
module neighbour_adapter (
   input wire logic first_i,
   input wire logic grant_up_n_i,
   input wire logic hog_i,
   input wire logic far_busy_i,
   output logic grant_n_o,
   output logic busy_oe_n_o
);
   assign grant_n_o = hog_i | (!first_i & grant_up_n_i);
   // pull and release busy
   // an adapter farther down the string may also hold the line
   assign busy_oe_n_o = !(hog_i | far_busy_i);
endmodule
`default_nettype wire

// [tb/drive_power_up_chain_and_init_tb_top.sv]
`timescale 1ns/1ps
`include "pwrseq_defs.svh"
`default_nettype none
module drive_power_up_chain_and_init_tb_top;
   logic clk, rst, cyc, stb, we, first, grant_up_n, hog, far_busy, start_en, dc_ok, ready, init_a, init_b;
   logic ack, err, err_seen, grant_in_n, grant_out_n, busy_n, busy_o, busy_oe_n, nb_oe_n;
   logic pick, hold, srelay, grelay;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rd_data, got;
   int n_mismatch, compares, n;
   // wired busy line with pull-up
   assign busy_n = (busy_oe_n ? 1'b1 : busy_o) & nb_oe_n;
   drive_power_up_chain_and_init #(.POWERUP_CYCLES(64'h0000_0000_0000_00C8)) dut (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_data), .wb_ack_o(ack), .wb_err_o(err),
      .grant_in_n_i(grant_in_n), .grant_out_n_o(grant_out_n), .seq_busy_n_i(busy_n),
      .seq_busy_n_o(busy_o), .seq_busy_oe_n_o(busy_oe_n), .start_enable_i(start_en),
      .dc_power_ok_i(dc_ok), .unit_ready_i(ready), .pick_o(pick), .hold_o(hold),
      .start_relay_o(srelay), .grant_relay_o(grelay), .bus_init_a_i(init_a), .bus_init_b_i(init_b));
   neighbour_adapter nb (.first_i(first), .grant_up_n_i(grant_up_n), .hog_i(hog), .far_busy_i(far_busy),
      .grant_n_o(grant_in_n), .busy_oe_n_o(nb_oe_n));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic end_sim();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic cycle, held until ack or err
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && err !== 1'b1 && k < 50);
      got = rd_data;
      err_seen = err;
      if (k >= 50) begin
         n_mismatch++;
         end_sim();
      end
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(nm, got, exp);
   endtask
   task automatic wait_oe(input logic v);
      n = 0;
      while (busy_oe_n !== v && n < 1000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 1000) begin
         n_mismatch++;
         end_sim();
      end
   endtask
   // clear from port a, port b and drive clear
   task automatic t_clear();
      for (int k = 0; k < 3; k++) begin
         wb(1'b1, `REG_MAINT2, 32'h0000_FFFF);
         wb(1'b1, `REG_ECC, 32'h0000_1234);
         wb(1'b1, `REG_ERR2, 32'h0000_5555);
         wb(1'b1, `REG_CTRL, 32'h0000_0001);
         rdchk("ctrl_set", `REG_CTRL, 32'h0000_0001);
         if (k == 0) init_a <= 1'b1;
         else if (k == 1) init_b <= 1'b1;
         else wb(1'b1, `REG_CTRL, 32'h0000_0004);
         repeat (8) @(posedge clk);
         init_a <= 1'b0; init_b <= 1'b0;
         repeat (8) @(posedge clk);
         rdchk("maint2", `REG_MAINT2, 32'h0000_FFFE);
         rdchk("ecc", `REG_ECC, 32'h0000_0000);
         rdchk("ctrl", `REG_CTRL, 32'h0000_0002);
         rdchk("err2", `REG_ERR2, 32'h0000_0000);
      end
      // power-good edge clears as well
      wb(1'b1, `REG_MAINT2, 32'h0000_FFFF);
      dc_ok <= 1'b0;
      repeat (8) @(posedge clk);
      dc_ok <= 1'b1;
      repeat (8) @(posedge clk);
      rdchk("pg_clear", `REG_MAINT2, 32'h0000_FFFE);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", {31'h0, err_seen}, 32'h1);
   endtask
   // upstream sequencing withholds grant; a busy line alone only delays
   task automatic t_chain();
      hog <= 1'b1; start_en <= 1'b1;
      repeat (12) @(posedge clk);
      chk("no_grant", {31'h0, grelay}, 32'h0);
      hog <= 1'b0; far_busy <= 1'b1;
      repeat (12) @(posedge clk);
      chk("relay", {31'h0, grelay}, 32'h1);
      chk("grant_blk", {31'h0, grant_out_n}, 32'h1);
      chk("wait_busy", {31'h0, busy_oe_n}, 32'h1);
      far_busy <= 1'b0;
      wait_oe(1'b0);
      chk("pick_hold", {30'h0, pick, hold}, 32'h0);
      chk("start_rly", {31'h0, srelay}, 32'h1);
      chk("busy_drv", {31'h0, busy_o}, 32'h0);
      ready <= 1'b1;
      wait_oe(1'b1);
      chk("grant_out", {31'h0, grant_out_n}, 32'h0);
      rdchk("attn_up", `REG_ATTN, 32'h0000_0001);
      init_b <= 1'b1;
      repeat (8) @(posedge clk);
      init_b <= 1'b0;
      rdchk("attn_clr", `REG_ATTN, 32'h0000_0000);
   endtask
   // stop the drive, grant passes through
   task automatic t_stop();
      start_en <= 1'b0;
      repeat (10) @(posedge clk);
      chk("stop", {29'h0, pick, hold, srelay}, 32'h6);
      ready <= 1'b0; first <= 1'b0; grant_up_n <= 1'b1;
      repeat (10) @(posedge clk);
      chk("pass_hi", {31'h0, grant_out_n}, 32'h1);
      grant_up_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk("pass_lo", {31'h0, grant_out_n}, 32'h0);
      first <= 1'b1;
   endtask
   // drive never ready: timeout, fault, clear, restart
   task automatic t_tmo();
      start_en <= 1'b1;
      wait_oe(1'b0);
      wait_oe(1'b1);
      chk("tmo_len", {31'h0, n >= 199 && n <= 202}, 32'h1);
      chk("tmo_grant", {31'h0, grant_out_n}, 32'h0);
      rdchk("err1", `REG_ERR1, 32'h0000_0001);
      repeat (20) @(posedge clk);
      chk("fail_hold", {30'h0, busy_oe_n, grant_out_n}, 32'h2);
      start_en <= 1'b0;
      repeat (8) @(posedge clk);
      init_a <= 1'b1;
      repeat (8) @(posedge clk);
      init_a <= 1'b0; ready <= 1'b1; start_en <= 1'b1;
      wait_oe(1'b0);
      wait_oe(1'b1);
      chk("restart", {31'h0, grant_out_n}, 32'h0);
      rdchk("err1_clr", `REG_ERR1, 32'h0000_0000);
   endtask
   initial begin
      rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h3; wdat = 32'h0;
      first = 1'b1; grant_up_n = 1'b1; hog = 1'b0; far_busy = 1'b0; start_en = 1'b0; dc_ok = 1'b1; ready = 1'b0;
      init_a = 1'b0; init_b = 1'b0; n_mismatch = 0; compares = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      t_clear();
      t_chain();
      t_stop();
      t_tmo();
      end_sim();
   end
endmodule
`default_nettype wire
